// ===== common/brai_pkg.sv
package brai_pkg;

  localparam int unsigned ADDR_W = 19;

  // Address bits that the straps can invert
  localparam int unsigned INV_BIT_8K  = 15;
  localparam int unsigned INV_BIT_16K = 16;
  localparam int unsigned INV_BIT_32K = 17;
  localparam int unsigned INV_BIT_64K = 18;

  localparam logic [ADDR_W-1:0] ADDR_RST     = 19'h00000;
  localparam logic [ADDR_W-1:0] MASK_NONE    = 19'h00000;
  localparam logic [ADDR_W-1:0] ONE_HOT_LSB  = 19'h00001;
  localparam logic              SELECT_N_RST = 1'b1;
  localparam logic              OE_RST       = 1'b0;

  typedef enum logic [1:0] {
    BRAI_SAMPLE = 2'b00,
    BRAI_RUN    = 2'b01
  } brai_state_t;

  typedef struct packed {
    logic rom_inversion_mode_strap;
    logic rom_size_strap_a;
    logic rom_size_strap_b;
  } brai_straps_t;

  localparam brai_straps_t STRAPS_RST = 3'h4;

endpackage

// ===== tb/boot_rom_address_inversion_test.sv
`timescale 1ns/1ps
module boot_rom_address_inversion_test;
  logic                        clk, rst, acc, mode, sa, sb, pin;
  logic                        sel_n, oe, vld;
  logic [brai_pkg::ADDR_W-1:0] addr, addr_o, mask;
  logic [31:0]                 seed = 32'hB712;
  int                          failures = 0;
  int                          comparisons = 0;

  brai_top dut_u (.ref_clk_i(clk), .reset_i(rst), .rom_access_i(acc),
    .rom_addr_i(addr), .bios_rom_select_i(pin),
    .bios_rom_select_n_o(sel_n), .bios_rom_select_oe_o(oe),
    .gate_a20_pin_i(sa), .ignore_numeric_error_pin_i(sb),
    .rom_addr_o(addr_o), .straps_valid_o(vld));
  brai_rom_model model_u (.strap_i(mode), .select_n_i(sel_n),
    .select_oe_i(oe), .pin_o(pin));

  function automatic logic [31:0] xs(input logic [31:0] x);
    logic [31:0] y;
    y = x ^ (x << 13);
    y = y ^ (y >> 17);
    return y ^ (y << 5);
  endfunction

  function automatic logic [18:0] exp_mask(input logic m, a, b);
    if (m)
      return brai_pkg::MASK_NONE;
    case ({a, b})
      2'b11:   return brai_pkg::ONE_HOT_LSB << 16;
      2'b10:   return brai_pkg::ONE_HOT_LSB << 17;
      2'b01:   return brai_pkg::ONE_HOT_LSB << 18;
      default: return brai_pkg::ONE_HOT_LSB << 15;
    endcase
  endfunction

  task check(input string what, input logic [18:0] seen, expd);
    comparisons++;
    if (seen !== expd)
    begin
      failures++;
      $display("[ERR] %s expected %h seen %h", what, expd, seen);
    end
  endtask

  task results;
    $display("failures %0d comparisons %0d", failures, comparisons);
    if (failures == 0 && comparisons > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  initial
  begin
    rst = 1'b1;
    acc = 1'b0;
    addr = '0;
    for (int c = 0; c < 8; c++)
    begin
      {mode, sa, sb} = c[2:0];
      // Access held high across reset and the sample edge
      acc = 1'b1;
      rst = 1'b1;
      repeat (3) @(posedge clk);
      #1 check("valid_in_reset", 19'(vld), 19'h00000);
      check("oe_in_reset", 19'(oe), 19'h00000);
      check("select_n_in_reset", 19'(sel_n), 19'h00001);
      check("addr_in_reset", addr_o, brai_pkg::ADDR_RST);
      rst = 1'b0;
      @(posedge clk);
      // Straps change after sampling and must be ignored
      #1 {mode, sa, sb} = ~c[2:0];
      mask = exp_mask(c[2], c[1], c[0]);
      check("straps_valid", 19'(vld), 19'h00001);
      check("select_oe", 19'(oe), 19'h00000);
      check("select_n_at_sample", 19'(sel_n), 19'h00001);
      for (int i = 0; i < 12; i++)
      begin
        seed = xs(seed);
        acc = seed[19];
        addr = (i == 0) ? 19'h00000 : (i == 1) ? 19'h7FFFF : seed[18:0];
        @(posedge clk);
        #1 check("rom_addr", addr_o, addr ^ mask);
        check("rom_select_n", 19'(sel_n), 19'(!acc));
        check("select_oe", 19'(oe), 19'h00001);
      end
    end
    results;
  end
endmodule

// ===== tb/brai_rom_model.sv
`timescale 1ns/1ps
module brai_rom_model
(
  input  wire logic strap_i,
  input  wire logic select_n_i,
  input  wire logic select_oe_i,
  output logic      pin_o
);
  // Strap resistor sets the line while the device lets it go
  assign pin_o = select_oe_i ? select_n_i : strap_i;
endmodule

// ===== verilog/brai_top.sv
`timescale 1ns/1ps

// Contract
// - Pin serves as BIOS ROM chip select
// - Sample mode and size straps at power-up
// - Mode strap high: no address inversion
// - Mode low, sizes high: invert bit 16
// - Mode low, A high, B low: bit 17
// - Mode low, A low, B high: bit 18
// - All straps low: invert bit 15
module brai_top
(
  input  wire logic                         ref_clk_i,
  input  wire logic                         reset_i,
  input  wire logic                         rom_access_i,
  input  wire logic [brai_pkg::ADDR_W-1:0]  rom_addr_i,
  input  wire logic                         bios_rom_select_i,
  output logic                              bios_rom_select_n_o,
  output logic                              bios_rom_select_oe_o,
  input  wire logic                         gate_a20_pin_i,
  input  wire logic                         ignore_numeric_error_pin_i,
  output logic [brai_pkg::ADDR_W-1:0]       rom_addr_o,
  output logic                              straps_valid_o
);

  brai_pkg::brai_state_t          state;
  brai_pkg::brai_state_t          next_state;
  brai_pkg::brai_straps_t         straps;
  brai_pkg::brai_straps_t         pin_straps;
  logic [brai_pkg::ADDR_W-1:0]    inv_mask;
  logic [brai_pkg::ADDR_W-1:0]    next_inv_mask;
  logic                           sampling;

  // Strap decode to a one-hot inversion mask, all zero when the mode strap is high
  function automatic logic [brai_pkg::ADDR_W-1:0] brai_mask
  (
    input brai_pkg::brai_straps_t s
  );
    logic [brai_pkg::ADDR_W-1:0] m;
    m = brai_pkg::MASK_NONE;
    if (s.rom_inversion_mode_strap)
    begin
      m = brai_pkg::MASK_NONE;
    end
    else
    begin
      case ({s.rom_size_strap_a, s.rom_size_strap_b})
        2'h3:    m = brai_pkg::ONE_HOT_LSB << brai_pkg::INV_BIT_16K;
        2'h2:    m = brai_pkg::ONE_HOT_LSB << brai_pkg::INV_BIT_32K;
        2'h1:    m = brai_pkg::ONE_HOT_LSB << brai_pkg::INV_BIT_64K;
        default: m = brai_pkg::ONE_HOT_LSB << brai_pkg::INV_BIT_8K;
      endcase
    end
    return m;
  endfunction

  assign sampling   = (state == brai_pkg::BRAI_SAMPLE);
  assign pin_straps = {bios_rom_select_i, gate_a20_pin_i,
                       ignore_numeric_error_pin_i};
  assign next_state = brai_pkg::BRAI_RUN;
  // Mask only changes in the sample cycle
  assign next_inv_mask = sampling ? brai_mask(pin_straps) : inv_mask;

  always_ff @(posedge ref_clk_i)
  begin
    if (reset_i)
    begin
      state    <= brai_pkg::BRAI_SAMPLE;
      straps   <= brai_pkg::STRAPS_RST;
      inv_mask <= brai_pkg::MASK_NONE;
    end
    else
    begin
      state    <= next_state;
      inv_mask <= next_inv_mask;
      if (sampling)
      begin
        straps <= pin_straps;
      end
    end
  end

  // Pin released while strapped, then driven as chip select
  always_ff @(posedge ref_clk_i)
  begin
    if (reset_i)
    begin
      bios_rom_select_n_o  <= brai_pkg::SELECT_N_RST;
      bios_rom_select_oe_o <= brai_pkg::OE_RST;
      rom_addr_o           <= brai_pkg::ADDR_RST;
      straps_valid_o       <= 1'b0;
    end
    else
    begin
      bios_rom_select_n_o  <= sampling | ~rom_access_i;
      bios_rom_select_oe_o <= ~sampling;
      rom_addr_o           <= rom_addr_i ^ next_inv_mask;
      straps_valid_o       <= 1'b1;
    end
  end

  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (reset_i);

  sequence s_run_two;
    (state == brai_pkg::BRAI_RUN) ##1 (state == brai_pkg::BRAI_RUN);
  endsequence

  sequence s_run_one;
    state == brai_pkg::BRAI_RUN;
  endsequence

  // Sample edge, then the first cycle on the latched straps
  sequence s_sample_edge;
    sampling ##1 s_run_one;
  endsequence

  AST_SELECT_FOLLOWS: assert property (
    s_run_two |-> bios_rom_select_oe_o &&
      (bios_rom_select_n_o == !$past(rom_access_i)))
    else $error("chip select does not follow rom access");

  AST_SAMPLE_CAPTURE: assert property (
    sampling |=> (straps == $past(pin_straps)) && !bios_rom_select_oe_o)
    else $error("straps not captured while pin released");

  AST_MODE_PASS: assert property (
    (!sampling && straps.rom_inversion_mode_strap)
      |=> rom_addr_o == $past(rom_addr_i))
    else $error("address changed in pass mode");

  AST_INV_16: assert property (
    (!sampling && straps == 3'h3)
      |=> rom_addr_o == ($past(rom_addr_i) ^ 19'h10000))
    else $error("bit 16 not inverted");

  AST_INV_17: assert property (
    (!sampling && straps == 3'h2)
      |=> rom_addr_o == ($past(rom_addr_i) ^ 19'h20000))
    else $error("bit 17 not inverted");

  AST_INV_18: assert property (
    (!sampling && straps == 3'h1)
      |=> rom_addr_o == ($past(rom_addr_i) ^ 19'h40000))
    else $error("bit 18 not inverted");

  AST_INV_15: assert property (
    (!sampling && straps == 3'h0)
      |=> rom_addr_o == ($past(rom_addr_i) ^ 19'h08000))
    else $error("bit 15 not inverted");

  AST_STRAPS_HELD: assert property (
    s_run_two |-> $stable(straps) && $stable(inv_mask) && straps_valid_o)
    else $error("latched straps changed after sampling");

  // Checked through reset, so the default disable is overridden
  AST_RESET_OUTPUTS: assert property (
    @(posedge ref_clk_i) disable iff (1'b0)
    reset_i |=> bios_rom_select_n_o && !bios_rom_select_oe_o &&
      (rom_addr_o == brai_pkg::ADDR_RST) && !straps_valid_o)
    else $error("outputs not at reset values during reset");

  AST_RESET_STATE: assert property (
    @(posedge ref_clk_i) disable iff (1'b0)
    reset_i |=> sampling)
    else $error("reset does not return to strap sampling");

  AST_PIN_RELEASED: assert property (
    sampling |-> !bios_rom_select_oe_o)
    else $error("pin driven while straps are sampled");

  AST_VALID_SET: assert property (
    sampling |=> straps_valid_o)
    else $error("straps valid not raised after sampling");

  AST_SAMPLE_REFUSED: assert property (
    sampling |=> bios_rom_select_n_o)
    else $error("chip select asserted at the sample edge");

  AST_SAMPLE_ONCE: assert property (
    s_sample_edge |=> (state == brai_pkg::BRAI_RUN) && straps_valid_o)
    else $error("straps sampled again without reset");

  // Only reset brings the strap sample back
  AST_RUN_HOLDS: assert property (
    s_run_one |=> s_run_one)
    else $error("left run state without reset");

  AST_VALID_STAYS: assert property (
    s_run_one |=> straps_valid_o)
    else $error("straps valid dropped after sampling");

  AST_RUN_DRIVES: assert property (
    s_run_one |=> bios_rom_select_oe_o)
    else $error("pin not driven in run state");

  // Chip select follows access from the first run cycle
  AST_SELECT_IDLE: assert property (
    (!sampling && !rom_access_i) |=> bios_rom_select_n_o)
    else $error("chip select asserted without rom access");

  AST_SELECT_ACTIVE: assert property (
    (!sampling && rom_access_i)
      |=> !bios_rom_select_n_o && bios_rom_select_oe_o)
    else $error("chip select missing on rom access");

  AST_PASS_MASK: assert property (
    (!sampling && straps.rom_inversion_mode_strap)
      |-> inv_mask == brai_pkg::MASK_NONE)
    else $error("inversion mask set in pass mode");

  AST_MASK_ONE_HOT: assert property (
    !sampling |-> $onehot0(inv_mask))
    else $error("more than one address bit inverted");

  // Bits below the lowest invertible bit always pass through
  AST_LOW_BITS_PASS: assert property (
    !sampling |=> rom_addr_o[brai_pkg::INV_BIT_8K-1:0] ==
      $past(rom_addr_i[brai_pkg::INV_BIT_8K-1:0]))
    else $error("low address bits altered");

endmodule
